// ==== design/can_wake_pattern_monitor.v ====
// Transceiver digital core: mode control, driver/receiver paths, wake pattern monitor
`include "can_wake_defines.vh"

// Operation
// RULE1 - Normal: transmit low drives bus dominant
// RULE2 - Normal: receive output mirrors bus state
// RULE3 - Standby: driver off, transmit ignored, weak pulldown
// RULE4 - Standby: low-power receiver and monitor stay active
// RULE5 - Controller watches falling receive, lowers standby
// RULE6 - Wake shown as falling edge, filtered low
// RULE7 - Pattern: dominant, recessive, dominant, all filtered
// RULE8 - Short unfiltered activity never resets monitor
// RULE9 - Second dominant wakes; later dominants drive low
// RULE10 - Filtered means longer than filter time
// RULE11 - Phases below minimum filter never count
// RULE12 - Phases above maximum filter always count
// RULE13 - Filter passes one 500k bit
// RULE14 - Any frame at 500k contains pattern
// RULE15 - Pattern must finish within timeout, else reset
// RULE16 - Remote resends full pattern after timeout
// RULE17 - Standby select high standby, low normal
// RULE18 - Standby: receive high until pattern seen
// RULE19 - Floating inputs default standby and recessive
// RULE20 - Leaving standby clears detector and timers
// RULE21 - Timers count synchronised bus samples
module can_wake_pattern_monitor #(
    parameter [`TOUT_CNT_W-1:0] WAKE_TIMEOUT_CYCLES = `WAKE_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire clk_in,
    input wire nrst_in,
    // Controller side pins
    input wire tx_data_in,
    input wire standby_select_in,
    output reg rx_data_out,
    // Bus side: receiver level (low = dominant) and driver controls
    input wire bus_rx_in,
    output reg bus_drive_dominant_out,
    output reg bus_bias_recessive_out,
    output reg bus_weak_ground_out,
    output reg standby_mode_out
);
    // State codes, one-hot
    localparam [3:0] IDLE_ST = `ST_IDLE;
    localparam [3:0] DOM1_ST = `ST_DOM1;
    localparam [3:0] REC_ST = `ST_REC;
    localparam [3:0] WOKE_ST = `ST_WOKE;
    localparam [`TOUT_CNT_W-1:0] TOUT_ONE = {{(`TOUT_CNT_W-1){1'b0}}, 1'b1};

    wire [2:0] pin_raw;
    wire [2:0] pin_sync;
    wire tx_level;
    wire bus_level;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [`TOUT_CNT_W-1:0] tout_reg;
    reg [`TOUT_CNT_W-1:0] tout_next;
    reg rx_next;
    reg drive_next;
    reg bias_next;
    reg ground_next;
    wire dom_pulse;
    wire rec_pulse;
    wire dom_level;
    wire standby;
    wire timed_out;
    wire wake_hit;
    genvar sync_idx;

    // Pins cross two flops; reset values model the pull-ups on floating pins
    assign pin_raw = {bus_rx_in, standby_select_in, tx_data_in};

    generate
        for (sync_idx = 0; sync_idx < 3; sync_idx = sync_idx + 1)
        begin : g_pin_sync
            reg [1:0] stage_reg;
            always @(posedge clk_in)
            begin
                if (!nrst_in)
                    stage_reg <= `SYNC_IDLE; // RULE19
                else
                    stage_reg <= {stage_reg[0], pin_raw[sync_idx]};
            end
            // Only the second stage is read, the first may be metastable
            assign pin_sync[sync_idx] = stage_reg[1];
        end
    endgenerate

    assign tx_level = pin_sync[0];
    assign standby = pin_sync[1]; // RULE17
    assign bus_level = pin_sync[2]; // RULE21

    // Filter runs only in standby so every standby entry starts fresh
    bus_phase_filter #(
        .FILTER_CYCLES(`WAKE_FILTER_CYCLES) // RULE13
    ) u_filter (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(~standby), // RULE20
        .bus_level_in(bus_level), // RULE4
        .dom_pulse_out(dom_pulse),
        .rec_pulse_out(rec_pulse),
        .dom_level_out(dom_level)
    );

    // Timeout is checked before any phase event, so a late phase never wakes
    assign timed_out = (tout_reg >= WAKE_TIMEOUT_CYCLES);
    assign wake_hit = (state_reg == REC_ST) && dom_pulse && !timed_out; // RULE9

    always @*
    begin
        state_next = state_reg;
        tout_next = tout_reg;
        case (state_reg)
            IDLE_ST:
            begin
                tout_next = {`TOUT_CNT_W{1'b0}};
                if (dom_pulse)
                    state_next = DOM1_ST; // RULE7
            end
            DOM1_ST:
            begin
                tout_next = tout_reg + TOUT_ONE;
                if (timed_out)
                    state_next = IDLE_ST; // RULE15
                else if (rec_pulse)
                    state_next = REC_ST; // RULE8
            end
            REC_ST:
            begin
                tout_next = tout_reg + TOUT_ONE;
                if (timed_out)
                    state_next = IDLE_ST; // RULE15
                else if (wake_hit)
                    state_next = WOKE_ST; // RULE9
            end
            WOKE_ST:
            begin
                tout_next = {`TOUT_CNT_W{1'b0}};
            end
            default:
            begin
                state_next = IDLE_ST;
                tout_next = {`TOUT_CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_in)
    begin
        if (!nrst_in || !standby)
        begin
            state_reg <= IDLE_ST; // RULE20
            tout_reg <= {`TOUT_CNT_W{1'b0}};
        end
        else
        begin
            state_reg <= state_next;
            tout_reg <= tout_next;
        end
    end

    // Receive pin: mirror in normal mode, wake indication in standby
    always @*
    begin
        if (!standby)
            rx_next = bus_level; // RULE2
        else if (state_reg == WOKE_ST)
            rx_next = ~dom_level; // RULE9
        else if (wake_hit)
            rx_next = 1'b0; // RULE6
        else
            rx_next = 1'b1; // RULE18
    end

    // Driver: follows transmit in normal mode, off with weak ground bias in standby
    always @*
    begin
        if (standby)
        begin
            drive_next = 1'b0; // RULE3
            bias_next = 1'b0;
            ground_next = 1'b1;
        end
        else
        begin
            drive_next = ~tx_level; // RULE1
            bias_next = tx_level;
            ground_next = 1'b0;
        end
    end

    // Wake low starts on the cycle after the second dominant qualifies
    always @(posedge clk_in)
    begin
        if (!nrst_in)
            rx_data_out <= 1'b1;
        else
            rx_data_out <= rx_next;
    end

    always @(posedge clk_in)
    begin
        if (!nrst_in)
            standby_mode_out <= 1'b1;
        else
            standby_mode_out <= standby;
    end

    // Driver outputs change on the same edge as the mode output
    always @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            bus_drive_dominant_out <= 1'b0;
            bus_bias_recessive_out <= 1'b0;
            bus_weak_ground_out <= 1'b1;
        end
        else
        begin
            bus_drive_dominant_out <= drive_next;
            bus_bias_recessive_out <= bias_next;
            bus_weak_ground_out <= ground_next;
        end
    end
endmodule // can_wake_pattern_monitor

// ==== design/can_wake_defines.vh ====
// Constants for the wake pattern monitor and mode logic
`ifndef CAN_WAKE_DEFINES_VH
`define CAN_WAKE_DEFINES_VH
`define CLK_FREQ_HZ 50000000
// Wake filter: 1 bit at 500 kbps = 2000 ns must pass, so filter sits below it
`define WAKE_FILTER_TIME_NS 1000
// Cycle counts at the 50 MHz clock, sized to the counters that load them
`define WAKE_FILTER_CYCLES 16'h0032
`define WAKE_TIMEOUT_TIME_US 1000
`define WAKE_TIMEOUT_CYCLES 24'h00c350
`define FILT_CNT_W 16
`define TOUT_CNT_W 24
// Synchroniser idle value, matching the pull-ups on floating pins
`define SYNC_IDLE 2'h3
`define ST_IDLE 4'h1
`define ST_DOM1 4'h2
`define ST_REC 4'h4
`define ST_WOKE 4'h8
`endif

// ==== design/bus_phase_filter.v ====
// Phase filter: pulses when the bus has held one state longer than the filter time
`include "can_wake_defines.vh"

module bus_phase_filter #(
    parameter [`FILT_CNT_W-1:0] FILTER_CYCLES = `WAKE_FILTER_CYCLES
) (
    // Clock and reset
    input wire clk_in,
    input wire nrst_in,
    input wire clear_in,
    // Synchronised bus level, low means dominant
    input wire bus_level_in,
    // Filtered phase events
    output reg dom_pulse_out,
    output reg rec_pulse_out,
    output reg dom_level_out
);
    reg [`FILT_CNT_W-1:0] cnt_reg;
    reg last_reg;
    reg fired_reg;

    always @(posedge clk_in)
    begin
        if (!nrst_in || clear_in)
        begin
            cnt_reg <= {`FILT_CNT_W{1'b0}};
            last_reg <= 1'b1;
            fired_reg <= 1'b0;
            dom_pulse_out <= 1'b0;
            rec_pulse_out <= 1'b0;
            dom_level_out <= 1'b0;
        end
        else
        begin
            dom_pulse_out <= 1'b0;
            rec_pulse_out <= 1'b0;
            if (bus_level_in != last_reg)
            begin
                // Each edge restarts the measurement of the new phase
                last_reg <= bus_level_in; // RULE10
                cnt_reg <= {`FILT_CNT_W{1'b0}};
                fired_reg <= 1'b0;
                dom_level_out <= 1'b0;
            end
            else if (!fired_reg)
            begin
                if (cnt_reg > FILTER_CYCLES)
                begin
                    // Strictly longer than the filter time counts
                    fired_reg <= 1'b1; // RULE11
                    dom_pulse_out <= ~bus_level_in; // RULE12
                    rec_pulse_out <= bus_level_in;
                    dom_level_out <= ~bus_level_in; // RULE14
                end
                else
                begin
                    cnt_reg <= cnt_reg + {{(`FILT_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // bus_phase_filter

// ==== verif/wake_monitor_assertions.sv ====
// Port checker for the wake pattern monitor
module wake_monitor_checker (
    // Clock and reset
    input wire clk_in,
    input wire nrst_in,
    // Pins
    input wire tx_data_in,
    input wire standby_select_in,
    input wire rx_data_out,
    input wire bus_rx_in,
    input wire bus_drive_dominant_out,
    input wire bus_bias_recessive_out,
    input wire bus_weak_ground_out,
    input wire standby_mode_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] up_reg;
    logic [2:0] norm_reg;
    logic [6:0] low_reg;
    logic [6:0] high_reg;
    logic steady;
    // Saturating cycles since reset and run lengths of each bus state; shift history of normal mode
    always @(posedge clk_in)
    begin
        up_reg <= !nrst_in ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
        norm_reg <= !nrst_in ? 3'h0 : {norm_reg[1:0], !standby_mode_out};
        low_reg <= (bus_rx_in || !nrst_in) ? 7'h0 : low_reg + {6'h0, low_reg != 7'h7f};
        high_reg <= (!bus_rx_in || !nrst_in) ? 7'h0 : high_reg + {6'h0, high_reg != 7'h7f};
    end
    // Normal mode settled, so pin paths are not mid-switch
    assign steady = (norm_reg == 3'h7) && !standby_mode_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_standby_drive_off:
        assert property (standby_mode_out |-> !bus_drive_dominant_out && bus_weak_ground_out)
        else $error("driver active in standby");
    a_normal_no_ground:
        assert property (!standby_mode_out |-> !bus_weak_ground_out)
        else $error("weak ground in normal mode");
    a_drive_follows_tx:
        assert property (steady |-> bus_drive_dominant_out == !$past(tx_data_in, 3))
        else $error("driver does not follow transmit");
    a_bias_follows_tx:
        assert property (steady |-> bus_bias_recessive_out == $past(tx_data_in, 3))
        else $error("recessive bias does not follow transmit");
    a_rx_mirrors_bus:
        assert property (steady |-> rx_data_out == $past(bus_rx_in, 3))
        else $error("receive does not mirror bus");
    a_mode_follows_select:
        assert property (up_reg == 3'h7 |-> standby_mode_out == $past(standby_select_in, 3))
        else $error("mode does not follow select");
    a_wake_after_filter:
        assert property (standby_mode_out && $past(standby_mode_out) && $fell(rx_data_out)
            |-> low_reg > 7'd50)
        else $error("wake low before filtered dominant");
    a_wake_low_ends:
        assert property (standby_mode_out && !rx_data_out |-> high_reg < 7'd8)
        else $error("wake low outlasts dominant");
endmodule // wake_monitor_checker

bind can_wake_pattern_monitor wake_monitor_checker u_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .tx_data_in(tx_data_in),
    .standby_select_in(standby_select_in), .rx_data_out(rx_data_out), .bus_rx_in(bus_rx_in),
    .bus_drive_dominant_out(bus_drive_dominant_out),
    .bus_bias_recessive_out(bus_bias_recessive_out),
    .bus_weak_ground_out(bus_weak_ground_out), .standby_mode_out(standby_mode_out));

// ==== verif/can_bus_model.sv ====
// Bus model: wired dominant of the local driver and a remote node
module can_bus_model (
    // Dominant requests onto the bus
    input wire drive_dominant_in,
    input wire remote_dominant_in,
    // Receiver level, low means dominant
    output wire bus_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Any dominant driver overrides the recessive bias
    assign bus_level_out = !(drive_dominant_in || remote_dominant_in);
endmodule // can_bus_model

// ==== verif/testbench.sv ====
// Testbench for the wake pattern monitor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic tx_data_in = 1'b1;
    logic standby_select_in = 1'b1;
    logic remote_dom = 1'b0;
    logic woke = 1'b0;
    wire rx_data_out;
    wire bus_rx;
    wire drive_dom;
    wire mode;
    wire bias;
    wire ground;
    int n_fail = 0;
    int total_checks = 0;
    always #10 clk_in = !clk_in;
    always @(posedge clk_in) if (!rx_data_out) woke <= 1'b1;
    can_bus_model u_bus (.drive_dominant_in(drive_dom), .remote_dominant_in(remote_dom),
        .bus_level_out(bus_rx));
    can_wake_pattern_monitor #(.WAKE_TIMEOUT_CYCLES(24'd500)) u_dut (.clk_in(clk_in),
        .nrst_in(nrst_in), .tx_data_in(tx_data_in), .standby_select_in(standby_select_in),
        .rx_data_out(rx_data_out), .bus_rx_in(bus_rx), .bus_drive_dominant_out(drive_dom),
        .bus_bias_recessive_out(bias), .bus_weak_ground_out(ground), .standby_mode_out(mode));
    task automatic check(input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic phase(input logic dom, input int n);
        remote_dom = dom;
        repeat (n) @(negedge clk_in);
    endtask
    task automatic set_mode(input logic stb);
        standby_select_in = stb;
        phase(1'b0, 6);
        woke = 1'b0;
    endtask
    task automatic t_normal;
        set_mode(1'b0);
        check(mode, 1'b0);
        tx_data_in = 1'b0;
        phase(1'b0, 8);
        check(drive_dom, 1'b1);
        check(bias, 1'b0);
        check(ground, 1'b0);
        check(rx_data_out, 1'b0);
        tx_data_in = 1'b1;
        phase(1'b0, 8);
        check(drive_dom, 1'b0);
        check(bias, 1'b1);
        check(rx_data_out, 1'b1);
    endtask
    task automatic t_wake;
        set_mode(1'b1);
        tx_data_in = 1'b0;
        phase(1'b0, 8);
        check(drive_dom, 1'b0);
        check(bias, 1'b0);
        check(ground, 1'b1);
        phase(1'b1, 70);
        phase(1'b0, 20);
        phase(1'b1, 10);
        phase(1'b0, 70);
        check(woke, 1'b0);
        phase(1'b1, 70);
        check(woke, 1'b1);
        tx_data_in = 1'b1;
        phase(1'b0, 20);
        woke = 1'b0;
        phase(1'b1, 70);
        check(woke, 1'b1);
    endtask
    task automatic t_restart;
        set_mode(1'b0);
        check(rx_data_out, 1'b1);
        set_mode(1'b1);
        phase(1'b1, 70);
        phase(1'b0, 10);
        check(woke, 1'b0);
        repeat (4)
        begin
            phase(1'b1, 40);
            phase(1'b0, 40);
        end
        check(woke, 1'b0);
    endtask
    task automatic t_timeout;
        set_mode(1'b0);
        set_mode(1'b1);
        phase(1'b1, 70);
        phase(1'b0, 600);
        phase(1'b1, 70);
        check(woke, 1'b0);
        phase(1'b0, 70);
        phase(1'b1, 70);
        check(woke, 1'b1);
    endtask
    task automatic t_bitrate;
        set_mode(1'b0);
        set_mode(1'b1);
        phase(1'b1, 100);
        phase(1'b0, 100);
        phase(1'b1, 100);
        check(woke, 1'b1);
        phase(1'b0, 10);
    endtask
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        phase(1'b0, 5);
        nrst_in = 1'b1;
        phase(1'b0, 4);
        check(mode, 1'b1);
        check(rx_data_out, 1'b1);
        t_normal;
        t_wake;
        t_restart;
        t_timeout;
        t_bitrate;
        complete_run;
    end
endmodule // testbench
